// ==== io_event_and_drive_regs.sv ====
// APB register slice for overcurrent, pin drive and input event flags.
//
// Local design decisions: the register addresses and the APB slave port.
module io_event_and_drive_regs
    import io_event_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
)
(
    // APB clock and reset.
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB request.
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [DATA_WIDTH-1:0] pwdata,
    input  wire logic [STRB_WIDTH-1:0] pstrb,
    // APB answer.
    output logic                       pready,
    output logic      [DATA_WIDTH-1:0] prdata,
    output logic                       pslverr,
    // Event sources.
    input  wire logic                  lowside_oc_event,
    input  wire logic                  timer_event,
    input  wire logic                  wake_input_one,
    input  wire logic                  wake_input_two,
    input  wire logic                  hv_pin_one_in,
    input  wire logic                  hv_pin_two_in,
    input  wire logic                  lv_pin_three_in,
    input  wire logic                  lv_pin_four_in,
    input  wire logic                  lv_input_five_in,
    // Input event mask held outside, and operating mode.
    input  wire logic [EVENT_COUNT-1:0] input_event_mask,
    input  wire logic                  normal_mode,
    // Pin direction configuration, high when the pin is an output.
    input  wire logic                  lv_output_six_is_out,
    input  wire logic                  lv_pin_four_is_out,
    input  wire logic                  lv_pin_three_is_out,
    input  wire logic                  hv_pin_two_is_out,
    input  wire logic                  hv_pin_one_is_out,
    // Pin output levels, high when released, low when driven low.
    output logic                       lv_output_six_level,
    output logic                       lv_pin_four_level,
    output logic                       lv_pin_three_level,
    output logic                       hv_pin_two_level,
    output logic                       hv_pin_one_level,
    // Interrupt request.
    output logic                       irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic                    decode_ok;
    logic                    sel_lowside_flag;
    logic                    sel_lowside_mask;
    logic                    sel_drive_req;
    logic                    sel_input_flags;
    logic                    setup_phase;
    logic                    write_take;
    logic [REG_WIDTH-1:0]    lane_mask;
    logic [REG_WIDTH-1:0]    wr_ones;
    logic [DATA_WIDTH-1:0]   rdata_d;
    logic                    slverr_d;
    logic [DATA_WIDTH-1:0]   prdata_q;
    logic                    pslverr_q;

    logic [0:0]              lowside_set;
    logic [0:0]              lowside_clear;
    logic [0:0]              lowside_flag_q;
    logic                    lowside_mask_q;

    logic [EVENT_COUNT-1:0]  input_level;
    logic [EVENT_COUNT-1:0]  input_prev_q;
    logic                    prev_valid_q;
    logic [EVENT_COUNT-1:0]  input_change;
    logic [EVENT_COUNT-1:0]  input_set;
    logic [EVENT_COUNT-1:0]  input_clear;
    logic [EVENT_COUNT-1:0]  input_flags_q;
    logic [EVENT_COUNT-1:0]  input_irq_enable;

    logic [PIN_COUNT-1:0]    pin_is_out;
    logic [PIN_COUNT-1:0]    pin_low_req;
    logic [PIN_COUNT-1:0]    pin_rel_req;
    logic [PIN_COUNT-1:0]    pin_level_q;
    logic [PIN_COUNT-1:0]    pin_level_d;

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks.

    if (ADDR_WIDTH < DECODE_WIDTH)
    begin : g_addr_check
        $error("ADDR_WIDTH must cover the register decode");
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB decode.

    // Registers sit in the low decode window; higher address bits must be zero.
    always_comb
    begin
        decode_ok        = (paddr >> DECODE_WIDTH) == '0;
        sel_lowside_flag = decode_ok
                           && paddr[DECODE_WIDTH-1:0] == OFS_LOWSIDE_FLAG;
        sel_lowside_mask = decode_ok
                           && paddr[DECODE_WIDTH-1:0] == OFS_LOWSIDE_MASK;
        sel_drive_req    = decode_ok
                           && paddr[DECODE_WIDTH-1:0] == OFS_DRIVE_REQ;
        sel_input_flags  = decode_ok
                           && paddr[DECODE_WIDTH-1:0] == OFS_INPUT_FLAGS;
    end

    // The slave never stalls; read data is prepared in the setup cycle.
    assign pready      = 1'b1;
    assign setup_phase = psel && !penable;
    assign write_take  = psel && penable && pwrite && pready;

    // Byte strobes gate which register bits a write can touch.
    always_comb
    begin
        lane_mask = {{(REG_WIDTH - LOW_LANE_MSB - 1){pstrb[1]}},
                     {(LOW_LANE_MSB + 1){pstrb[0]}}};
        wr_ones   = pwdata[REG_WIDTH-1:0] & lane_mask;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path.

    // Read mux; unused bits and the request register read as zero.
    always_comb
    begin
        rdata_d  = RDATA_RESET;
        slverr_d = 1'b0;
        if (sel_lowside_flag)
            rdata_d[LOWSIDE_OC_BIT] = lowside_flag_q[0];
        else if (sel_lowside_mask)
            rdata_d[LOWSIDE_OC_BIT] = lowside_mask_q;
        else if (sel_drive_req)
            rdata_d = RDATA_RESET;
        else if (sel_input_flags)
            rdata_d[EVENT_COUNT-1:0] = input_flags_q;
        else
            slverr_d = 1'b1;
    end

    // Capture the answer in the setup cycle so it is stable in the access.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= RDATA_RESET;
            pslverr_q <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata_q  <= pwrite ? RDATA_RESET : rdata_d;
            pslverr_q <= slverr_d;
        end
    end

    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////////////
    // Low-side overcurrent flag and mask.

    assign lowside_set[0]   = lowside_oc_event;
    assign lowside_clear[0] = write_take && sel_lowside_flag
                              && wr_ones[LOWSIDE_OC_BIT];

    sticky_flags #(
        .WIDTH       (1)
    ) u_lowside_flags (
        .pclk        (pclk),
        .presetn     (presetn),
        .set_pulse   (lowside_set),
        .clear_pulse (lowside_clear),
        .flags_q     (lowside_flag_q)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lowside_mask_q <= REG_RESET[LOWSIDE_OC_BIT];
        else if (write_take && sel_lowside_mask && lane_mask[LOWSIDE_OC_BIT])
            lowside_mask_q <= pwdata[LOWSIDE_OC_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input change detection.

    // Gather the watched inputs at their flag positions; the spare bit stays 0.
    always_comb
    begin
        input_level                      = EVENT_RESET;
        input_level[WAKE_ONE_BIT]        = wake_input_one;
        input_level[WAKE_TWO_BIT]        = wake_input_two;
        input_level[PIN_EVENT_LSB]       = hv_pin_one_in;
        input_level[PIN_EVENT_LSB + 1]   = hv_pin_two_in;
        input_level[PIN_EVENT_LSB + 2]   = lv_pin_three_in;
        input_level[PIN_EVENT_LSB + 3]   = lv_pin_four_in;
        input_level[PIN_EVENT_LSB + 4]   = lv_input_five_in;
    end

    // Previous levels; the first cycle after reset only loads, so a level
    // already present at reset is not taken for a change.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            input_prev_q <= EVENT_RESET;
            prev_valid_q <= 1'b0;
        end
        else
        begin
            input_prev_q <= input_level;
            prev_valid_q <= 1'b1;
        end
    end

    // Set and clear terms for the input event flags.
    always_comb
    begin
        input_change = (input_level ^ input_prev_q)
                       & {EVENT_COUNT{prev_valid_q}};
        input_set    = input_change & ~input_event_mask;
        input_set[TIMER_EVENT_BIT] = timer_event;
        input_set[UNUSED_BIT]      = 1'b0;
        input_clear  = {EVENT_COUNT{write_take && sel_input_flags}}
                       & wr_ones[EVENT_COUNT-1:0];
    end

    sticky_flags #(
        .WIDTH       (EVENT_COUNT)
    ) u_input_flags (
        .pclk        (pclk),
        .presetn     (presetn),
        .set_pulse   (input_set),
        .clear_pulse (input_clear),
        .flags_q     (input_flags_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive requests.

    // Direction configuration in pair order.
    assign pin_is_out[PIN_LV_SIX]   = lv_output_six_is_out;
    assign pin_is_out[PIN_LV_FOUR]  = lv_pin_four_is_out;
    assign pin_is_out[PIN_LV_THREE] = lv_pin_three_is_out;
    assign pin_is_out[PIN_HV_TWO]   = hv_pin_two_is_out;
    assign pin_is_out[PIN_HV_ONE]   = hv_pin_one_is_out;

    // Split the write into low and release requests per pin.
    always_comb
    begin
        for (int k = 0; k < PIN_COUNT; k++)
        begin
            pin_low_req[k] = write_take && sel_drive_req && wr_ones[2 * k];
            pin_rel_req[k] = write_take && sel_drive_req
                             && wr_ones[2 * k + 1];
        end
    end

    // Next pin level; drive low wins if both halves of a pair are written.
    always_comb
    begin
        pin_level_d = pin_level_q;
        for (int k = 0; k < PIN_COUNT; k++)
        begin
            if (pin_is_out[k])
            begin
                if (pin_low_req[k])
                    pin_level_d[k] = 1'b0;
                else if (pin_rel_req[k])
                    pin_level_d[k] = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_level_q <= PIN_LEVEL_RESET;
        else
            pin_level_q <= pin_level_d;
    end

    assign lv_output_six_level = pin_level_q[PIN_LV_SIX];
    assign lv_pin_four_level   = pin_level_q[PIN_LV_FOUR];
    assign lv_pin_three_level  = pin_level_q[PIN_LV_THREE];
    assign hv_pin_two_level    = pin_level_q[PIN_HV_TWO];
    assign hv_pin_one_level    = pin_level_q[PIN_HV_ONE];

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt.

    // Input interrupts need a clear mask; state changes also need normal mode.
    always_comb
    begin
        input_irq_enable = ~input_event_mask & {EVENT_COUNT{normal_mode}};
        input_irq_enable[TIMER_EVENT_BIT] = ~input_event_mask[TIMER_EVENT_BIT];
    end

    assign irq = (lowside_flag_q[0] && !lowside_mask_q)
                 || |(input_flags_q & input_irq_enable);

endmodule : io_event_and_drive_regs

// ==== io_event_pkg.sv ====
// Constants shared by the I/O event and pin drive register block.
package io_event_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus and register widths.
    localparam int DATA_WIDTH   = 32;
    localparam int REG_WIDTH    = 16;
    localparam int DECODE_WIDTH = 8;
    localparam int STRB_WIDTH   = DATA_WIDTH / 8;
    localparam int PIN_COUNT    = 5;
    localparam int EVENT_COUNT  = 9;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [DECODE_WIDTH-1:0] OFS_LOWSIDE_FLAG = 8'h00;
    localparam logic [DECODE_WIDTH-1:0] OFS_LOWSIDE_MASK = 8'h04;
    localparam logic [DECODE_WIDTH-1:0] OFS_DRIVE_REQ    = 8'h08;
    localparam logic [DECODE_WIDTH-1:0] OFS_INPUT_FLAGS  = 8'h0C;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int LOWSIDE_OC_BIT  = 0;
    localparam int WAKE_ONE_BIT    = 0;
    localparam int WAKE_TWO_BIT    = 1;
    localparam int UNUSED_BIT      = 2;
    localparam int PIN_EVENT_LSB   = 3;
    localparam int TIMER_EVENT_BIT = 8;
    localparam int LOW_LANE_MSB    = 7;

    // Pin index order, which is also the drive request pair order.
    localparam int PIN_LV_SIX   = 0;
    localparam int PIN_LV_FOUR  = 1;
    localparam int PIN_LV_THREE = 2;
    localparam int PIN_HV_TWO   = 3;
    localparam int PIN_HV_ONE   = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [REG_WIDTH-1:0]   REG_RESET       = 16'h0000;
    localparam logic [EVENT_COUNT-1:0] EVENT_RESET     = 9'h000;
    localparam logic [PIN_COUNT-1:0]   PIN_LEVEL_RESET = 5'h1F;
    localparam logic [DATA_WIDTH-1:0]  RDATA_RESET     = 32'h0000_0000;

endpackage : io_event_pkg

// ==== sticky_flags.sv ====
// Bank of sticky event flags with write-one-to-clear.
module sticky_flags
    import io_event_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    // Clock and reset.
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Set and clear requests, one bit per flag.
    input  wire logic [WIDTH-1:0] set_pulse,
    input  wire logic [WIDTH-1:0] clear_pulse,
    // Stored flags.
    output logic      [WIDTH-1:0] flags_q
);

    logic [WIDTH-1:0] flags_d;

    // Elaboration check on the bank width.
    if (WIDTH < 1)
    begin : g_width_check
        $error("sticky_flags needs at least one flag");
    end

    // A set arriving with a clear wins, so no event is lost.
    always_comb
    begin
        flags_d = (flags_q & ~clear_pulse) | set_pulse;
    end

    // Flags start cleared at power-on.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_q <= '0;
        else
            flags_q <= flags_d;
    end

endmodule : sticky_flags

// ==== io_event_monitor.sv ====
// Checker for the I/O event and pin drive register block.
module io_event_monitor
    import io_event_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
)
(
    // Bus side.
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [ADDR_WIDTH-1:0]  paddr,
    input wire logic [DATA_WIDTH-1:0]  pwdata,
    input wire logic [STRB_WIDTH-1:0]  pstrb,
    input wire logic [DATA_WIDTH-1:0]  prdata,
    // Events, one pin and the interrupt.
    input wire logic                   timer_event,
    input wire logic                   wake_input_one,
    input wire logic [EVENT_COUNT-1:0] input_event_mask,
    input wire logic                   normal_mode,
    input wire logic                   lv_output_six_is_out,
    input wire logic                   lv_output_six_level,
    input wire logic                   irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////
    // Read access and a drive request write that reaches pin six.
    logic rd_acc;
    logic wr_drv;
    assign rd_acc = psel && penable && !pwrite;
    assign wr_drv = psel && penable && pwrite && pstrb[0]
        && paddr == ADDR_WIDTH'(OFS_DRIVE_REQ) && lv_output_six_is_out;

    ////////////////////////////////////////////////////////////////////////
    // Properties.
    property p_rst_quiet;
        $rose(presetn) |-> !irq && lv_output_six_level;
    endproperty
    property p_drv_reads_zero;
        rd_acc && paddr == ADDR_WIDTH'(OFS_DRIVE_REQ) |-> prdata == '0;
    endproperty
    property p_unused_zero;
        rd_acc && paddr == ADDR_WIDTH'(OFS_INPUT_FLAGS)
            |-> prdata[31:9] == '0 && !prdata[2];
    endproperty
    property p_drive_low;
        wr_drv && pwdata[0] |=> !lv_output_six_level;
    endproperty
    property p_release;
        wr_drv && pwdata[1:0] == 2'h2 |=> lv_output_six_level;
    endproperty
    property p_hold;
        !(wr_drv && |pwdata[1:0]) |=> $stable(lv_output_six_level);
    endproperty
    property p_timer_irq;
        timer_event && !input_event_mask[8] |=> irq;
    endproperty
    property p_wake_irq;
        $changed(wake_input_one) && $past(presetn) && normal_mode
            && !input_event_mask[0]
            |=> irq || input_event_mask[0] || !normal_mode;
    endproperty

    a_rst_quiet: assert property (p_rst_quiet)
        else $error("irq or pin level wrong after reset");
    a_drv_reads_zero: assert property (p_drv_reads_zero)
        else $error("drive request read not zero");
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused event bits not zero");
    a_drive_low: assert property (p_drive_low)
        else $error("pin not driven low");
    a_release: assert property (p_release)
        else $error("pin not released");
    a_hold: assert property (p_hold)
        else $error("pin changed without request");
    a_timer_irq: assert property (p_timer_irq)
        else $error("timer event gave no irq");
    a_wake_irq: assert property (p_wake_irq)
        else $error("wake change gave no irq");

    c_drive: cover property (wr_drv && pwdata[0]);
    c_timer: cover property (timer_event ##1 irq);
    c_wake: cover property ($changed(wake_input_one) && normal_mode);
endmodule : io_event_monitor

bind io_event_and_drive_regs io_event_monitor
    #(.ADDR_WIDTH(ADDR_WIDTH)) mon (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .timer_event,
    .wake_input_one, .input_event_mask, .normal_mode,
    .lv_output_six_is_out, .lv_output_six_level, .irq);

// ==== io_event_and_drive_regs_tb_top.sv ====
// Self-checking bench for the I/O event and pin drive register block.
module io_event_and_drive_regs_tb_top
    import io_event_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Bench signals.
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [3:0]  pstrb   = 4'hF;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        oc_ev   = 1'b0;
    logic        tm_ev   = 1'b0;
    logic [6:0]  in_v    = 7'h00;
    logic [8:0]  msk     = 9'h000;
    logic        nm      = 1'b1;
    logic [4:0]  is_out  = 5'h00;
    logic [4:0]  lvl;
    logic        irq;
    logic [31:0] rq;
    logic        re;
    int          error_cnt = 0;
    int          compares  = 0;

    // Clock at 200 MHz.
    always #2.5 pclk = ~pclk;

    io_event_and_drive_regs dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .lowside_oc_event(oc_ev), .timer_event(tm_ev),
        .wake_input_one(in_v[0]), .wake_input_two(in_v[1]),
        .hv_pin_one_in(in_v[2]), .hv_pin_two_in(in_v[3]),
        .lv_pin_three_in(in_v[4]), .lv_pin_four_in(in_v[5]),
        .lv_input_five_in(in_v[6]), .input_event_mask(msk),
        .normal_mode(nm), .lv_output_six_is_out(is_out[0]),
        .lv_pin_four_is_out(is_out[1]), .lv_pin_three_is_out(is_out[2]),
        .hv_pin_two_is_out(is_out[3]), .hv_pin_one_is_out(is_out[4]),
        .lv_output_six_level(lvl[0]), .lv_pin_four_level(lvl[1]),
        .lv_pin_three_level(lvl[2]), .hv_pin_two_level(lvl[3]),
        .hv_pin_one_level(lvl[4]), .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    // Bus cycles and comparison.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {4'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask : apb

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rq, exp);
    endtask : rd_chk

    // Toggle one input at a rising edge, then let the next edge take it,
    // so that the flag it sets is stored before the next read's setup.
    // Index 0 to 6 is an event input, 7 overcurrent, 8 timer, 9 mode.
    task automatic flip(input int k);
        @(posedge pclk);
        case (k)
            7: oc_ev <= ~oc_ev;
            8: tm_ev <= ~tm_ev;
            9: nm <= ~nm;
            default: in_v <= in_v ^ (7'h01 << k);
        endcase
        @(posedge pclk);
        @(negedge pclk);
    endtask : flip

    ////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_reset;
        rd_chk(OFS_LOWSIDE_FLAG, 32'h0);
        rd_chk(OFS_LOWSIDE_MASK, 32'h0);
        rd_chk(OFS_DRIVE_REQ, 32'h0);
        rd_chk(OFS_INPUT_FLAGS, 32'h0);
        chk(32'(lvl), 32'h1F);
        chk(32'(irq), 32'h0);
        rd_chk(8'h10, 32'h0);
        chk(32'(re), 32'h1);
        $display("done t_reset");
    endtask : t_reset

    task automatic t_oc;
        flip(7);
        flip(7);
        chk(32'(irq), 32'h1);
        rd_chk(OFS_LOWSIDE_FLAG, 32'h1);
        apb(1'b1, OFS_LOWSIDE_FLAG, 32'h0);
        rd_chk(OFS_LOWSIDE_FLAG, 32'h1);
        apb(1'b1, OFS_LOWSIDE_MASK, 32'hFFFF);
        rd_chk(OFS_LOWSIDE_MASK, 32'h1);
        chk(32'(irq), 32'h0);
        apb(1'b1, OFS_LOWSIDE_MASK, 32'h0);
        chk(32'(irq), 32'h1);
        apb(1'b1, OFS_LOWSIDE_FLAG, 32'hFFFF);
        rd_chk(OFS_LOWSIDE_FLAG, 32'h0);
        chk(32'(irq), 32'h0);
        $display("done t_oc");
    endtask : t_oc

    task automatic t_drive;
        @(posedge pclk);
        is_out <= 5'h1F;
        for (int i = 0; i < PIN_COUNT; i++)
        begin
            apb(1'b1, OFS_DRIVE_REQ, 32'h1 << (2 * i));
            chk(32'(lvl), 32'(5'h1F & ~(5'h01 << i)));
            rd_chk(OFS_DRIVE_REQ, 32'h0);
            apb(1'b1, OFS_DRIVE_REQ, 32'h0);
            chk(32'(lvl), 32'(5'h1F & ~(5'h01 << i)));
            apb(1'b1, OFS_DRIVE_REQ, 32'h2 << (2 * i));
            chk(32'(lvl), 32'h1F);
        end
        apb(1'b1, OFS_DRIVE_REQ, 32'h155);
        chk(32'(lvl), 32'h0);
        @(posedge pclk);
        is_out <= 5'h00;
        apb(1'b1, OFS_DRIVE_REQ, 32'h2AA);
        chk(32'(lvl), 32'h0);
        @(posedge pclk);
        is_out <= 5'h1F;
        apb(1'b1, OFS_DRIVE_REQ, 32'h2AA);
        chk(32'(lvl), 32'h1F);
        $display("done t_drive");
    endtask : t_drive

    task automatic t_event;
        logic [31:0] exp;
        exp = 32'h0;
        for (int i = 0; i < 7; i++)
        begin
            flip(i);
            exp = exp | (32'h1 << (i < 2 ? i : i + 1));
            rd_chk(OFS_INPUT_FLAGS, exp);
        end
        chk(32'(irq), 32'h1);
        flip(8);
        flip(8);
        rd_chk(OFS_INPUT_FLAGS, exp | 32'h100);
        apb(1'b1, OFS_INPUT_FLAGS, 32'hFFFF);
        rd_chk(OFS_INPUT_FLAGS, 32'h0);
        chk(32'(irq), 32'h0);
        @(posedge pclk);
        msk <= 9'h1FF;
        in_v <= ~in_v;
        // Let the masked changes reach the flags before the read's setup.
        @(posedge pclk);
        rd_chk(OFS_INPUT_FLAGS, 32'h0);
        @(posedge pclk);
        msk <= 9'h000;
        nm <= 1'b0;
        flip(0);
        rd_chk(OFS_INPUT_FLAGS, 32'h1);
        chk(32'(irq), 32'h0);
        flip(9);
        chk(32'(irq), 32'h1);
        $display("done t_event");
    endtask : t_event

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run.
    task automatic end_sim;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    // Main sequence after a five cycle reset.
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_oc;
        t_drive;
        t_event;
        end_sim;
    end

    // Watchdog well beyond the expected run length.
    initial
    begin
        #20000;
        error_cnt++;
        end_sim;
    end
endmodule : io_event_and_drive_regs_tb_top
